/* logic/fduc_defines.svh */
// Address map, field positions, reset values and bit timing of the UART.
// Assumes byte addressing on the plain register port.
`ifndef FDUC_DEFINES_SVH
`define FDUC_DEFINES_SVH

`define FDUC_ADDR_TXBUF     8'hB6
`define FDUC_ADDR_RXBUF     8'hB7
`define FDUC_ADDR_DIV_LO    8'hB8
`define FDUC_ADDR_DIV_HI    8'hB9
`define FDUC_ADDR_CTRL      8'hBA
`define FDUC_ADDR_RXSTAT    8'hBB
`define FDUC_ADDR_IRQCLK    8'hBC

`define FDUC_RST_CTRL       8'h01
`define FDUC_RST_RXSTAT     8'h00
`define FDUC_RST_IRQCLK     8'h00
`define FDUC_RST_DIV        16'h0000

`define FDUC_CTRL_PAR_ON    7
`define FDUC_CTRL_PTYPE_HI  6
`define FDUC_CTRL_NINTH     5
`define FDUC_CTRL_LEN_HI    4
`define FDUC_CTRL_LEN_LO    3
`define FDUC_CTRL_ERR       2
`define FDUC_CTRL_RX_BUFFER_FULL      1
`define FDUC_CTRL_TX_BUFFER_EMPTY      0

`define FDUC_RXS_DOE        7
`define FDUC_RXS_FE         6
`define FDUC_RXS_PE         5
`define FDUC_RXS_SPARE      4
`define FDUC_RXS_NINTH      3
`define FDUC_RXS_ATTENTION_MODE       2
`define FDUC_RXS_TXACT      1
`define FDUC_RXS_RX_FRAMING_ACTIVE       0

`define FDUC_IC_TWO_STOP    7
`define FDUC_IC_SHORT_STOP  6
`define FDUC_IC_PIN_ON      5
`define FDUC_IC_SYNC        4
`define FDUC_IC_RX_EXT      3
`define FDUC_IC_TX_EXT      2
`define FDUC_IC_RX_IRQ      1
`define FDUC_IC_TX_IRQ      0

// Sixteen x16 ticks per bit; the start check falls after eight
`define FDUC_TICK_LAST      4'hF
`define FDUC_TICK_SHORT     4'hD
`define FDUC_TICK_HALF      4'h7

`endif

/* logic/fduc_pkg.sv */
// Types shared by the UART: bit-phase states and the whole state record.
// Assumes fduc_defines.svh holds all numbers.
package fduc_pkg;

  typedef enum logic [2:0] {
    PH_IDLE, PH_START, PH_DATA, PH_PAR, PH_STOP
  } fduc_phase_e;

  typedef struct packed {
    logic [7:0]  transmit_holding_buffer;
    logic        tx_buffer_empty;
    fduc_phase_e tx_ph;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_idx;
    logic [8:0]  tx_shift;
    logic        tx_par;
    logic        tx_line;
    logic        tx_active;
    logic [7:0]  receive_holding_buffer;
    logic        rx_buffer_full;
    logic        rx_ninth_bit;
    fduc_phase_e rx_ph;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_shift;
    logic        rx_par;
    logic        rx_perr;
    logic        pe;
    logic        fe;
    logic        overrun_fault;
    logic        rx_framing_active;
    logic [4:0]  ctrl;
    logic        attention_mode;
    logic        spare;
    logic [7:0]  icsel;
    logic [15:0] div;
    logic [15:0] div_cnt;
    logic        bclk;
    logic        ckx_prev;
    logic [7:0]  rd_data;
    logic        sout;
    logic        ckx_o;
    logic        ckx_oe;
    logic        tx_irq;
    logic        rx_irq;
  } fduc_state_s;

endpackage : fduc_pkg

/* logic/fduc_uart.sv */
// Full-duplex UART with double-buffered transmit and receive paths.
// Assumes a plain register port, pins already synchronous to ref_clk_in.
//
// How it works
// - Transmit-empty sets on load into shifter, clears on buffer write
// - Receive-full sets when a character lands, clears on buffer read
// - Global error bit is the OR of overrun, framing, parity
// - Length bits: 00 eight, 01 seven, 10 nine data bits
// - Length 11 loops transmitter to receiver with nine-bit frames
// - Shared bit is ninth transmit bit, else low parity select
// - Parity codes 00 and 01 odd, 10 one, 11 zero
// - Parity only when enabled and only in seven or eight bit frames
// - Framing error raises receive-activity bit until line returns high
// - Transmitting bit holds until the last stop bit ends
// - Attention bit clears on a character with ninth bit set
// - Ninth received bit kept as read-only status
// - Error flags sticky, cleared by reading them as one
// - Enable bits gate transmit and receive interrupts
// - Each direction picks internal generator or external clock pin
// - Mode bit zero asynchronous, one synchronous
// - Transmit pin from UART only when pin-enable set, else port data
// - Short-stop bit makes last stop seven eighths of a bit
// - Stop-count bit zero one stop, one two stops
// - Receive data from its own pin, except length 11, which takes it from the transmitter
// - Clock pin outputs generator clock or inputs an external clock
// - Reset clears all bits except transmit-empty, read-only ignore writes
// - Transmit interrupt pending while empty and enabled
// - Receive interrupt pending while full and enabled
// - Asynchronous bits take sixteen x16 ticks
// - Start bit checked at half bit, then one sample mid-bit
`include "fduc_defines.svh"

module fduc_uart (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rd_data_out,
  input  wire logic       serial_in_pin_in,
  output logic            serial_out_pin_out,
  input  wire logic       port_l2_data_in,
  input  wire logic       ext_baud_clock_pin_in,
  output logic            ext_baud_clock_pin_out,
  output logic            ext_baud_clock_pin_oe_out,
  input  wire logic       ckx_dir_out_in,
  output logic            tx_irq_out,
  output logic            rx_irq_out
);

  fduc_pkg::fduc_state_s st_reg;
  fduc_pkg::fduc_state_s st_next;

  logic       par_on;
  logic       ptype_hi;
  logic       ninth_sel;
  logic [1:0] flen;
  logic       nine;
  logic       loop;
  logic       par_en;
  logic [3:0] nbits_m1;
  logic       sync_mode;
  logic       int_tick;
  logic       int_rise;
  logic       int_fall;
  logic       ext_rise;
  logic       ext_fall;
  logic       tx_tick;
  logic       rx_tick;
  logic       transmit_holding_buffer_wr;
  logic       receive_holding_buffer_rd;
  logic       rxs_rd;
  logic       tx_load;
  logic       tx_end;
  logic       tx_last_stop;
  logic       rx_line;
  logic       rx_sample;
  logic       rx_done;

  //////////////////////////////////////////////////////////////////////////
  // Frame decode and clock selection

  always_comb begin
    par_on    = st_reg.ctrl[4];
    ptype_hi  = st_reg.ctrl[3];
    ninth_sel = st_reg.ctrl[2];
    flen      = st_reg.ctrl[1:0];
    nine      = flen[1];
    loop      = &flen;
    par_en    = par_on && !nine;
    unique case (flen)
      2'b00:   nbits_m1 = 4'h7;
      2'b01:   nbits_m1 = 4'h6;
      default: nbits_m1 = 4'h8;
    endcase
    sync_mode = st_reg.icsel[`FDUC_IC_SYNC];
    int_tick  = (st_reg.div != 16'h0000) && (st_reg.div_cnt == 16'h0000);
    int_rise  = int_tick && !st_reg.bclk;
    int_fall  = int_tick && st_reg.bclk;
    ext_rise  = ext_baud_clock_pin_in && !st_reg.ckx_prev;
    ext_fall  = !ext_baud_clock_pin_in && st_reg.ckx_prev;
    // Sync mode moves one bit per clock: send on rise, sample on fall
    if (st_reg.icsel[`FDUC_IC_TX_EXT]) begin
      tx_tick = ext_rise;
    end else begin
      tx_tick = sync_mode ? int_rise : int_tick;
    end
    if (st_reg.icsel[`FDUC_IC_RX_EXT]) begin
      rx_tick = sync_mode ? ext_fall : ext_rise;
    end else begin
      rx_tick = sync_mode ? int_fall : int_tick;
    end
    transmit_holding_buffer_wr = wr_in && (addr_in == `FDUC_ADDR_TXBUF);
    receive_holding_buffer_rd = rd_in && (addr_in == `FDUC_ADDR_RXBUF);
    rxs_rd  = rd_in && (addr_in == `FDUC_ADDR_RXSTAT);
    rx_line = loop ? st_reg.tx_line : serial_in_pin_in;
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit and receive timing helpers

  always_comb begin
    // A buffer write in the same cycle delays the load one cycle
    tx_load      = !st_reg.tx_buffer_empty && !transmit_holding_buffer_wr;
    tx_last_stop = (st_reg.tx_idx ==
                    {3'h0, st_reg.icsel[`FDUC_IC_TWO_STOP]});
    if (sync_mode) begin
      tx_end = 1'b1;
    end else if (st_reg.tx_ph == fduc_pkg::PH_STOP && tx_last_stop &&
                 st_reg.icsel[`FDUC_IC_SHORT_STOP]) begin
      tx_end = (st_reg.tx_cnt == `FDUC_TICK_SHORT);
    end else begin
      tx_end = (st_reg.tx_cnt == `FDUC_TICK_LAST);
    end
    rx_sample = sync_mode || (st_reg.rx_cnt == `FDUC_TICK_LAST);
    rx_done   = rx_tick && rx_sample && (st_reg.rx_ph == fduc_pkg::PH_STOP);
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [8:0] rx_word;
    logic       keep;
    rx_word = 9'h000;
    keep    = 1'b0;
    st_next = st_reg;
    st_next.ckx_prev = ext_baud_clock_pin_in;
    // Baud generator; a divisor of zero stops the clock
    if (st_reg.div == 16'h0000) begin
      st_next.div_cnt = 16'h0000;
    end else if (st_reg.div_cnt == 16'h0000) begin
      st_next.div_cnt = st_reg.div - 16'h0001;
      st_next.bclk    = !st_reg.bclk;
    end else begin
      st_next.div_cnt = st_reg.div_cnt - 16'h0001;
    end

    // Transmitter
    if (st_reg.tx_ph == fduc_pkg::PH_IDLE) begin
      if (tx_load) begin
        st_next.tx_shift  = {ninth_sel, st_reg.transmit_holding_buffer};
        st_next.tx_buffer_empty      = 1'b1;
        st_next.tx_active = 1'b1;
        st_next.tx_ph     = fduc_pkg::PH_START;
        st_next.tx_cnt    = 4'h0;
        st_next.tx_line   = 1'b0;
      end
    end else if (tx_tick) begin
      st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
      if (tx_end) begin
        st_next.tx_cnt = 4'h0;
        unique case (st_reg.tx_ph)
          fduc_pkg::PH_START: begin
            st_next.tx_ph   = fduc_pkg::PH_DATA;
            st_next.tx_idx  = 4'h0;
            st_next.tx_par  = 1'b0;
            st_next.tx_line = st_reg.tx_shift[0];
          end
          fduc_pkg::PH_DATA: begin
            st_next.tx_par   = st_reg.tx_par ^ st_reg.tx_shift[0];
            st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
            st_next.tx_idx   = st_reg.tx_idx + 4'h1;
            st_next.tx_line  = st_reg.tx_shift[1];
            if (st_reg.tx_idx == nbits_m1) begin
              st_next.tx_idx = 4'h0;
              if (par_en) begin
                st_next.tx_ph = fduc_pkg::PH_PAR;
                unique case ({ptype_hi, ninth_sel})
                  2'b10:   st_next.tx_line = 1'b1;
                  2'b11:   st_next.tx_line = 1'b0;
                  default: st_next.tx_line =
                             ~(st_reg.tx_par ^ st_reg.tx_shift[0]);
                endcase
              end else begin
                st_next.tx_ph   = fduc_pkg::PH_STOP;
                st_next.tx_line = 1'b1;
              end
            end
          end
          fduc_pkg::PH_PAR: begin
            st_next.tx_ph   = fduc_pkg::PH_STOP;
            st_next.tx_idx  = 4'h0;
            st_next.tx_line = 1'b1;
          end
          fduc_pkg::PH_STOP: begin
            if (!tx_last_stop) begin
              st_next.tx_idx = st_reg.tx_idx + 4'h1;
            end else if (tx_load) begin
              st_next.tx_shift = {ninth_sel, st_reg.transmit_holding_buffer};
              st_next.tx_buffer_empty     = 1'b1;
              st_next.tx_ph    = fduc_pkg::PH_START;
              st_next.tx_line  = 1'b0;
            end else begin
              st_next.tx_ph     = fduc_pkg::PH_IDLE;
              st_next.tx_active = 1'b0;
            end
          end
          default: st_next.tx_ph = fduc_pkg::PH_IDLE;
        endcase
      end
    end

    // Software side effects first, so that hardware sets win
    if (receive_holding_buffer_rd) begin
      st_next.rx_buffer_full = 1'b0;
    end
    if (rxs_rd) begin
      st_next.pe  = 1'b0;
      st_next.fe  = 1'b0;
      st_next.overrun_fault = 1'b0;
    end
    if (rx_line) begin
      st_next.rx_framing_active = 1'b0;
    end

    // Receiver
    if (rx_tick) begin
      st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
      unique case (st_reg.rx_ph)
        fduc_pkg::PH_IDLE: begin
          if (!rx_line) begin
            st_next.rx_cnt = 4'h0;
            st_next.rx_idx = 4'h0;
            st_next.rx_par = 1'b0;
            st_next.rx_ph  = sync_mode ? fduc_pkg::PH_DATA
                                       : fduc_pkg::PH_START;
          end
        end
        fduc_pkg::PH_START: begin
          if (st_reg.rx_cnt == `FDUC_TICK_HALF) begin
            st_next.rx_cnt = 4'h0;
            st_next.rx_ph  = rx_line ? fduc_pkg::PH_IDLE
                                     : fduc_pkg::PH_DATA;
          end
        end
        fduc_pkg::PH_DATA: begin
          if (rx_sample) begin
            st_next.rx_cnt   = 4'h0;
            st_next.rx_shift = {rx_line, st_reg.rx_shift[8:1]};
            st_next.rx_par   = st_reg.rx_par ^ rx_line;
            st_next.rx_idx   = st_reg.rx_idx + 4'h1;
            st_next.rx_perr  = 1'b0;
            if (st_reg.rx_idx == nbits_m1) begin
              st_next.rx_ph = par_en ? fduc_pkg::PH_PAR
                                     : fduc_pkg::PH_STOP;
            end
          end
        end
        fduc_pkg::PH_PAR: begin
          if (rx_sample) begin
            st_next.rx_cnt = 4'h0;
            st_next.rx_ph  = fduc_pkg::PH_STOP;
            unique case ({ptype_hi, ninth_sel})
              2'b10:   st_next.rx_perr = !rx_line;
              2'b11:   st_next.rx_perr = rx_line;
              default: st_next.rx_perr = (st_reg.rx_par ^ rx_line) == 1'b0;
            endcase
          end
        end
        fduc_pkg::PH_STOP: begin
          // Receiver checks one stop bit whatever the transmit setting
          if (rx_sample) begin
            st_next.rx_cnt = 4'h0;
            st_next.rx_ph  = fduc_pkg::PH_IDLE;
          end
        end
        default: st_next.rx_ph = fduc_pkg::PH_IDLE;
      endcase
    end
    if (rx_done) begin
      unique case (flen)
        2'b00:   rx_word = {1'b0, st_reg.rx_shift[8:1]};
        2'b01:   rx_word = {2'b00, st_reg.rx_shift[8:2]};
        default: rx_word = st_reg.rx_shift;
      endcase
      // Attention drops characters whose ninth bit is clear
      keep = !(st_reg.attention_mode && nine && !rx_word[8]);
      if (!rx_line) begin
        st_next.fe   = 1'b1;
        st_next.rx_framing_active = 1'b1;
      end
      if (st_reg.rx_perr) begin
        st_next.pe = 1'b1;
      end
      if (keep) begin
        st_next.receive_holding_buffer  = rx_word[7:0];
        st_next.rx_ninth_bit = nine ? rx_word[8] : 1'b0;
        st_next.rx_buffer_full  = 1'b1;
        if (st_reg.rx_buffer_full && !receive_holding_buffer_rd) begin
          st_next.overrun_fault = 1'b1;
        end
        if (nine && rx_word[8]) begin
          st_next.attention_mode = 1'b0;
        end
      end
    end

    // Register writes; read-only bits are never written
    if (wr_in) begin
      unique case (addr_in)
        `FDUC_ADDR_TXBUF: begin
          st_next.transmit_holding_buffer = wr_data_in;
          st_next.tx_buffer_empty = 1'b0;
        end
        `FDUC_ADDR_DIV_LO:  st_next.div[7:0]  = wr_data_in;
        `FDUC_ADDR_DIV_HI:  st_next.div[15:8] = wr_data_in;
        `FDUC_ADDR_CTRL:    st_next.ctrl = wr_data_in[7:3];
        `FDUC_ADDR_RXSTAT: begin
          st_next.spare = wr_data_in[`FDUC_RXS_SPARE];
          st_next.attention_mode  = wr_data_in[`FDUC_RXS_ATTENTION_MODE];
        end
        `FDUC_ADDR_IRQCLK:  st_next.icsel = wr_data_in;
        default: ;
      endcase
    end

    // Read data, valid in the cycle after the strobe
    st_next.rd_data = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `FDUC_ADDR_TXBUF:  st_next.rd_data = st_reg.transmit_holding_buffer;
        `FDUC_ADDR_RXBUF:  st_next.rd_data = st_reg.receive_holding_buffer;
        `FDUC_ADDR_DIV_LO: st_next.rd_data = st_reg.div[7:0];
        `FDUC_ADDR_DIV_HI: st_next.rd_data = st_reg.div[15:8];
        `FDUC_ADDR_CTRL:   st_next.rd_data = {st_reg.ctrl,
                             st_reg.pe | st_reg.fe | st_reg.overrun_fault,
                             st_reg.rx_buffer_full, st_reg.tx_buffer_empty};
        `FDUC_ADDR_RXSTAT: st_next.rd_data = {st_reg.overrun_fault, st_reg.fe,
                             st_reg.pe, st_reg.spare, st_reg.rx_ninth_bit,
                             st_reg.attention_mode, st_reg.tx_active, st_reg.rx_framing_active};
        `FDUC_ADDR_IRQCLK: st_next.rd_data = st_reg.icsel;
        default:           st_next.rd_data = 8'h00;
      endcase
    end

    // Pins and interrupt levels, all registered
    st_next.sout = st_reg.icsel[`FDUC_IC_PIN_ON] ? st_reg.tx_line
                                                 : port_l2_data_in;
    st_next.ckx_oe = ckx_dir_out_in;
    st_next.ckx_o  = st_reg.bclk;
    st_next.tx_irq = st_reg.tx_buffer_empty && st_reg.icsel[`FDUC_IC_TX_IRQ];
    st_next.rx_irq = st_reg.rx_buffer_full && st_reg.icsel[`FDUC_IC_RX_IRQ];
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; the clock enable freezes everything

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg         <= '0;
      st_reg.tx_buffer_empty    <= 1'b1;
      st_reg.tx_line <= 1'b1;
      st_reg.sout    <= 1'b1;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out               = st_reg.rd_data;
  assign serial_out_pin_out        = st_reg.sout;
  assign ext_baud_clock_pin_out    = st_reg.ckx_o;
  assign ext_baud_clock_pin_oe_out = st_reg.ckx_oe;
  assign tx_irq_out                = st_reg.tx_irq;
  assign rx_irq_out                = st_reg.rx_irq;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  tx_empty_clear_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && transmit_holding_buffer_wr |=> !st_reg.tx_buffer_empty && st_reg.transmit_holding_buffer == $past(wr_data_in))
    else $error("buffer write did not clear transmit empty");

  rx_full_clear_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && receive_holding_buffer_rd && !rx_done |=> !st_reg.rx_buffer_full)
    else $error("receive buffer read did not clear full flag");

  err_summary_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && rd_in && addr_in == `FDUC_ADDR_CTRL |=>
      rd_data_out[`FDUC_CTRL_ERR] == $past(st_reg.pe | st_reg.fe | st_reg.overrun_fault))
    else $error("global error bit wrong");

  tx_active_idle_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    st_reg.tx_active == (st_reg.tx_ph != fduc_pkg::PH_IDLE))
    else $error("transmitting bit disagrees with transmitter phase");

  rx_framing_active_release_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && rx_line |=> !st_reg.rx_framing_active)
    else $error("receive-activity bit kept with line high");

  err_sticky_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    st_reg.fe && !(clk_en_in && rxs_rd) |=> st_reg.fe)
    else $error("framing flag lost without status read");

  tx_pin_mux_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && !st_reg.icsel[`FDUC_IC_PIN_ON] |=>
      serial_out_pin_out == $past(port_l2_data_in))
    else $error("transmit pin not following port data");

  tx_irq_gate_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in |=>
      tx_irq_out == $past(st_reg.tx_buffer_empty && st_reg.icsel[`FDUC_IC_TX_IRQ]))
    else $error("transmit interrupt level wrong");

  rx_irq_gate_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in |=>
      rx_irq_out == $past(st_reg.rx_buffer_full && st_reg.icsel[`FDUC_IC_RX_IRQ]))
    else $error("receive interrupt level wrong");

  overrun_set_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    clk_en_in && rx_done && st_reg.rx_buffer_full && !receive_holding_buffer_rd &&
      !(st_reg.attention_mode && nine) |=> st_reg.overrun_fault && st_reg.rx_buffer_full)
    else $error("overrun not flagged");

endmodule : fduc_uart

/* verification/fduc_peer.sv */
// Remote serial peer: sends async frames, samples nine bit slots sent to it.
// Assumes divisor 1, so one bit lasts sixteen reference clocks.
module fduc_peer (
  input  wire logic ref_clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 16;
  logic [8:0] got = 9'h000;
  int         n_got = 0;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Nine slots: data, then parity, stop or idle, whichever the frame has
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge ref_clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk_in);
      got[i] = line_in;
    end
    n_got++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Stop level low on request to provoke a framing fault; line idles high
  task automatic send(input logic [7:0] d, input logic stop_lvl);
    logic [9:0] fr;
    fr = {stop_lvl, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_in);
      line_out <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk_in);
  endtask : send
endmodule : fduc_peer

/* verification/tb.sv */
// Register-level bench for the UART with a serial peer on its pins.
// Assumes the register port answers reads exactly one cycle later.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_b = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic       sout, sin, ck_o, ck_oe, tirq, rirq;
  logic       cen = 1'b1, l2 = 1'b1, ckp;
  int         n_errors = 0, tests_run = 0, nx = 0;
  logic [7:0] c_tab [7] = '{8'h00, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'h08, 8'h30};
  logic [7:0] d_tab [7] = '{8'hA5, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  logic [8:0] e_tab [7] = '{9'h1A5, 9'h001, 9'h001, 9'h101, 9'h001, 9'h181,
                            9'h101};
  always #50 clk = ~clk;
  fduc_uart i_fduc_uart (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(cen),
    .addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdat), .serial_in_pin_in(sin), .serial_out_pin_out(sout),
    .port_l2_data_in(l2), .ext_baud_clock_pin_in(1'b0),
    .ext_baud_clock_pin_out(ck_o), .ext_baud_clock_pin_oe_out(ck_oe),
    .ckx_dir_out_in(1'b1), .tx_irq_out(tirq), .rx_irq_out(rirq));
  fduc_peer i_fduc_peer (.ref_clk_in(clk), .line_in(sout), .line_out(sin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #10 chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rdat & m});
  endtask : rd_chk
  task automatic wait_got();
    nx++;
    for (int i = 0; i < 400 && i_fduc_peer.n_got != nx; i++) @(posedge clk);
    chk("peer frames", nx, i_fduc_peer.n_got);
  endtask : wait_got
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // Whole plan needs about 2400 cycles; a hang is cut well after that
  initial begin
    #(10000 * 100);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'hBA, 8'hFF, 8'h01);
    rd_chk(8'hBB, 8'hFF, 8'h00);
    rd_chk(8'hBC, 8'hFF, 8'h00);
    rd_chk(8'h10, 8'hFF, 8'h00);
    wr_reg(8'hBB, 8'hFF);
    rd_chk(8'hBB, 8'hFF, 8'h14);
    wr_reg(8'hBB, 8'h00);
    wr_reg(8'hB8, 8'h01);
    wr_reg(8'hBC, 8'h23);
    repeat (2) @(posedge clk);
    #10 chk("tx irq", 1, tirq);
    chk("clock oe", 1, ck_oe);
    ckp = ck_o;
    @(posedge clk);
    #10 chk("clock out", !ckp, ck_o);
    // A write with the clock enable low must leave the register alone
    @(posedge clk);
    cen <= 1'b0;
    wr_reg(8'hBC, 8'h00);
    cen <= 1'b1;
    rd_chk(8'hBC, 8'hFF, 8'h23);
    // Frame length, parity codes and ninth bit seen on the transmit pin
    for (int k = 0; k < 7; k++) begin
      wr_reg(8'hBA, c_tab[k]);
      wr_reg(8'hB6, d_tab[k]);
      rd_chk(8'hBB, 8'h02, 8'h02);
      wait_got();
      chk("tx frame", e_tab[k], i_fduc_peer.got);
      repeat (40) @(posedge clk);
      rd_chk(8'hBB, 8'h02, 8'h00);
    end
    // Line break: pin enable off, port data low reaches the pin
    wr_reg(8'hBC, 8'h03);
    l2 <= 1'b0;
    repeat (2) @(posedge clk);
    #10 chk("break level", 0, sout);
    wr_reg(8'hBC, 8'h23);
    l2 <= 1'b1;
    wr_reg(8'hBA, 8'h00);
    i_fduc_peer.send(8'h3C, 1'b1);
    repeat (4) @(posedge clk);
    chk("rx irq", 1, rirq);
    rd_chk(8'hBA, 8'h02, 8'h02);
    rd_chk(8'hB7, 8'hFF, 8'h3C);
    rd_chk(8'hBA, 8'h02, 8'h00);
    // Missing stop bit: sticky until the status read that returns it
    i_fduc_peer.send(8'h55, 1'b0);
    rd_chk(8'hBA, 8'h04, 8'h04);
    rd_chk(8'hBB, 8'h40, 8'h40);
    rd_chk(8'hBB, 8'h40, 8'h00);
    rd_chk(8'hB7, 8'hFF, 8'h55);
    i_fduc_peer.send(8'h11, 1'b1);
    i_fduc_peer.send(8'h22, 1'b1);
    rd_chk(8'hBB, 8'h80, 8'h80);
    rd_chk(8'hB7, 8'hFF, 8'h22);
    // Loopback in nine-bit frames; attention drops on a ninth bit of one
    wr_reg(8'hBB, 8'h04);
    wr_reg(8'hBA, 8'h38);
    wr_reg(8'hB6, 8'h5A);
    repeat (200) @(posedge clk);
    rd_chk(8'hB7, 8'hFF, 8'h5A);
    rd_chk(8'hBB, 8'h0C, 8'h08);
    tally_and_finish();
  end
endmodule : tb
